// >>> design/ssc_top.sv
// serial configuration port and power/tuning control of a dual-PLL synth
// assumes the host drives serial_clk well below clock/4; pins are async
module ssc_top (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire logic                  serial_clk,
	input  wire logic                  serial_enable_n,
	input  wire logic                  serial_data_in,
	input  wire logic                  power_down_n_pin,
	input  wire logic                  pd_update_tick,
	output ssc_pkg::ssc_div_t          dividers,
	output logic [17:0]                main_cfg,
	output logic [17:0]                gain_cfg,
	output logic [1:0]                 if_output_divide,
	output logic [3:0]                 if_divide_ratio,
	output logic                       low_band_synth_sel,
	output logic                       if_pll_on,
	output logic                       rf_pll_on,
	output logic                       if_tuning,
	output logic                       rf_tuning,
	output logic                       lock_detect_n,
	output logic                       word_commit,
	output ssc_pkg::ssc_pwr_ev_t       power_events
);

	// sync order: {serial_clk, enable_n, data, power pin}
	logic [3:0] sync1_reg;
	logic [3:0] sync1_next;
	logic [3:0] sync2_reg;
	logic [3:0] sync2_next;
	logic [2:0] prev_reg;
	logic [2:0] prev_next;

	always_comb
	begin
		sync1_next = {serial_clk, serial_enable_n, serial_data_in,
			power_down_n_pin};
		sync2_next = sync1_reg;
		prev_next  = {sync2_reg[3], sync2_reg[2], sync2_reg[0]};
	end

	// idle levels so release of reset makes no false edge on the link
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			sync1_reg <= 4'h4;
			sync2_reg <= 4'h4;
			prev_reg  <= 3'h2;
		end
		else
		begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			prev_reg  <= prev_next;
		end
	end

	logic sclk_rise;
	logic en_rise;
	logic pin_rise;
	logic pin_fall;
	logic en_n_s;
	logic data_s;
	logic pin_s;

	assign en_n_s    = sync2_reg[2];
	assign data_s    = sync2_reg[1];
	assign pin_s     = sync2_reg[0];
	assign sclk_rise = sync2_reg[3] & ~prev_reg[2];
	assign en_rise   = sync2_reg[2] & ~prev_reg[1];
	assign pin_rise  = sync2_reg[0] & ~prev_reg[0];
	assign pin_fall  = ~sync2_reg[0] & prev_reg[0];

	logic [ssc_pkg::WORD_W-1:0] shift_reg;
	logic [ssc_pkg::WORD_W-1:0] shift_next;

	always_comb
	begin
		shift_next = shift_reg;
		// oldest bit falls off the top
		if (sclk_rise && !en_n_s)
			shift_next = {shift_reg[ssc_pkg::WORD_W-2:0], data_s};
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			shift_reg <= '0;
		else
			shift_reg <= shift_next;
	end

	logic [ssc_pkg::ADDR_W-1:0] w_addr;
	logic [ssc_pkg::DATA_W-1:0] w_data;
	assign w_addr = shift_reg[ssc_pkg::ADDR_W-1:0];
	assign w_data = shift_reg[ssc_pkg::WORD_W-1:ssc_pkg::ADDR_W];

	logic [17:0]          main_reg;
	logic [17:0]          main_next;
	logic [17:0]          gain_reg;
	logic [17:0]          gain_next;
	logic [17:0]          pwr_reg;
	logic [17:0]          pwr_next;
	ssc_pkg::ssc_div_t    div_reg;
	ssc_pkg::ssc_div_t    div_next;
	logic                 band_low_reg;
	logic                 band_low_next;
	logic [3:0]           ratio_reg;
	logic [3:0]           ratio_next;
	logic                 commit_reg;
	logic                 if_on_reg;
	logic                 if_on_next;
	logic                 rf_on_reg;
	logic                 rf_on_next;
	ssc_pkg::ssc_pwr_ev_t ev_reg;
	ssc_pkg::ssc_pwr_ev_t ev_next;
	logic                 if_freq;
	logic                 rf_freq;
	logic                 pwr_write;

	always_comb
	begin
		main_next     = main_reg;
		gain_next     = gain_reg;
		pwr_next      = pwr_reg;
		div_next      = div_reg;
		band_low_next = band_low_reg;
		if_freq       = 1'b0;
		rf_freq       = 1'b0;
		pwr_write     = 1'b0;
		// last RF divider written picks band
		if (en_rise)
		begin
			case (w_addr)
				ssc_pkg::ADDR_MAIN: main_next = w_data;
				ssc_pkg::ADDR_GAIN: gain_next = w_data;
				ssc_pkg::ADDR_PWR:
				begin
					pwr_next  = w_data;
					pwr_write = 1'b1;
				end
				ssc_pkg::ADDR_N_HI:
				begin
					div_next.hi_n = w_data;
					band_low_next = 1'b0;
					rf_freq       = 1'b1;
				end
				ssc_pkg::ADDR_N_LO:
				begin
					div_next.lo_n = w_data;
					band_low_next = 1'b1;
					rf_freq       = 1'b1;
				end
				ssc_pkg::ADDR_N_IF:
				begin
					div_next.if_n = w_data;
					if_freq       = 1'b1;
				end
				ssc_pkg::ADDR_R_HI:
				begin
					div_next.hi_r = w_data;
					band_low_next = 1'b0;
					rf_freq       = 1'b1;
				end
				ssc_pkg::ADDR_R_LO:
				begin
					div_next.lo_r = w_data;
					band_low_next = 1'b1;
					rf_freq       = 1'b1;
				end
				ssc_pkg::ADDR_R_IF:
				begin
					div_next.if_r = w_data;
					if_freq       = 1'b1;
				end
				default: ;
			endcase
		end
		// ratio 1, 2, 4 or 8
		ratio_next = 4'h1 << main_next[ssc_pkg::IF_OUTPUT_DIVIDE_LSB +: 2];
		// a PLL runs only with the pin high and its software bit set
		if_on_next = pin_s & pwr_next[ssc_pkg::IF_PWR_BIT];
		rf_on_next = pin_s & pwr_next[ssc_pkg::RF_PWR_BIT];
		ev_next.pup_req = pin_rise | (pwr_write
			& w_data[ssc_pkg::IF_PWR_BIT] & w_data[ssc_pkg::RF_PWR_BIT]);
		ev_next.pdn_req = pin_fall | (pwr_write
			& ~w_data[ssc_pkg::IF_PWR_BIT] & ~w_data[ssc_pkg::RF_PWR_BIT]);
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			main_reg     <= ssc_pkg::DATA_RST;
			gain_reg     <= ssc_pkg::DATA_RST;
			pwr_reg      <= ssc_pkg::PWR_RST;
			div_reg      <= '0;
			band_low_reg <= 1'b0;
			ratio_reg    <= 4'h1;
			commit_reg   <= 1'b0;
			if_on_reg    <= 1'b0;
			rf_on_reg    <= 1'b0;
			ev_reg       <= '0;
		end
		else
		begin
			main_reg     <= main_next;
			gain_reg     <= gain_next;
			pwr_reg      <= pwr_next;
			div_reg      <= div_next;
			band_low_reg <= band_low_next;
			ratio_reg    <= ratio_next;
			commit_reg   <= en_rise;
			if_on_reg    <= if_on_next;
			rf_on_reg    <= rf_on_next;
			ev_reg       <= ev_next;
		end
	end

	// tuning starts on power-up or new frequency
	logic [ssc_pkg::PLL_COUNT-1:0] on_now;
	logic [ssc_pkg::PLL_COUNT-1:0] on_was;
	logic [ssc_pkg::PLL_COUNT-1:0] freq_new;
	logic [ssc_pkg::PLL_COUNT-1:0] tune_start;
	logic [ssc_pkg::PLL_COUNT-1:0] run_next;
	logic [ssc_pkg::PLL_COUNT-1:0] run_reg;
	assign on_now     = {rf_on_next, if_on_next};
	assign on_was     = {rf_on_reg, if_on_reg};
	assign freq_new   = {rf_freq, if_freq};
	assign tune_start = on_now & (~on_was | freq_new);

	genvar gi;
	generate
		for (gi = 0; gi < ssc_pkg::PLL_COUNT; gi++)
		begin : g_tune
			ssc_pkg::ssc_tune_t st_reg;
			ssc_pkg::ssc_tune_t st_next;
			logic [3:0]         cnt_reg;
			logic [3:0]         cnt_next;

			always_comb
			begin
				st_next  = st_reg;
				cnt_next = cnt_reg;
				case (st_reg)
					ssc_pkg::TN_IDLE: ;
					ssc_pkg::TN_RUN:
					begin
						if (pd_update_tick)
						begin
							if (cnt_reg == ssc_pkg::TUNE_PERIODS - 4'h1)
								st_next = ssc_pkg::TN_IDLE;
							else
								cnt_next = cnt_reg + 4'h1;
						end
					end
					default: st_next = ssc_pkg::TN_IDLE;
				endcase
				if (tune_start[gi])
				begin
					st_next  = ssc_pkg::TN_RUN;
					cnt_next = 4'h0;
				end
				else if (!on_now[gi])
					st_next = ssc_pkg::TN_IDLE;
			end

			always_ff @(posedge clock)
			begin
				if (!rst_n)
				begin
					st_reg  <= ssc_pkg::TN_IDLE;
					cnt_reg <= 4'h0;
				end
				else
				begin
					st_reg  <= st_next;
					cnt_reg <= cnt_next;
				end
			end

			assign run_next[gi] = (st_next == ssc_pkg::TN_RUN);
		end
	endgenerate

	logic lock_n_reg;
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			run_reg    <= '0;
			lock_n_reg <= 1'b0;
		end
		else
		begin
			run_reg    <= run_next;
			lock_n_reg <= |run_next;
		end
	end

	assign dividers           = div_reg;
	assign main_cfg           = main_reg;
	assign gain_cfg           = gain_reg;
	assign if_output_divide   = main_reg[ssc_pkg::IF_OUTPUT_DIVIDE_LSB +: 2];
	assign if_divide_ratio    = ratio_reg;
	assign low_band_synth_sel = band_low_reg;
	assign if_pll_on          = if_on_reg;
	assign rf_pll_on          = rf_on_reg;
	assign if_tuning          = run_reg[ssc_pkg::PLL_IF];
	assign rf_tuning          = run_reg[ssc_pkg::PLL_RF];
	assign lock_detect_n      = lock_n_reg;
	assign word_commit        = commit_reg;
	assign power_events       = ev_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_shift_in: assert property (
		sclk_rise && !en_n_s |=> shift_reg ==
			{$past(shift_reg[20:0]), $past(data_s)})
		else $error("shift missed a bit");
	a_shift_hold: assert property (
		en_n_s |=> $stable(shift_reg))
		else $error("shift moved while disabled");
	a_commit_hi: assert property (
		en_rise && w_addr == ssc_pkg::ADDR_N_HI |=>
			div_reg.hi_n == $past(w_data) && !band_low_reg)
		else $error("high band N not committed");
	a_band_low: assert property (
		en_rise && (w_addr == ssc_pkg::ADDR_N_LO ||
			w_addr == ssc_pkg::ADDR_R_LO) |=> band_low_reg)
		else $error("low band not selected");
	a_unmapped: assert property (
		en_rise && w_addr > ssc_pkg::ADDR_R_IF |=>
			$stable(div_reg) && $stable(pwr_reg) && $stable(main_reg))
		else $error("unmapped write changed state");
	a_pup_pin: assert property (
		pin_rise |=> power_events.pup_req && !power_events.pdn_req)
		else $error("pin rise gave no power-up");
	a_pdn_pin: assert property (
		pin_fall |=> power_events.pdn_req ##1 !rf_pll_on && !if_pll_on)
		else $error("pin fall gave no power-down");
	a_tune_start: assert property (
		tune_start[ssc_pkg::PLL_RF] |=> rf_tuning && lock_detect_n)
		else $error("rf tuning did not start");
	a_lock_high: assert property (
		lock_detect_n == (g_tune[0].st_reg == ssc_pkg::TN_RUN
			|| g_tune[1].st_reg == ssc_pkg::TN_RUN))
		else $error("lock indication differs from tuning state");

	c_word: cover property (en_rise && w_addr == ssc_pkg::ADDR_N_LO);
	c_pup_sw: cover property (pwr_write ##1 power_events.pup_req);
	c_tune_end: cover property (rf_tuning ##1 !rf_tuning && rf_pll_on);
endmodule : ssc_top

// >>> design/ssc_pkg.sv
// shared constants and types for the synthesizer serial config port
// assumes one system clock; the serial pins arrive from another domain
package ssc_pkg;
	localparam int WORD_W = 22;
	localparam int DATA_W = 18;
	localparam int ADDR_W = 4;

	localparam logic [3:0] ADDR_MAIN = 4'h0;
	localparam logic [3:0] ADDR_GAIN = 4'h1;
	localparam logic [3:0] ADDR_PWR  = 4'h2;
	localparam logic [3:0] ADDR_N_HI = 4'h3;
	localparam logic [3:0] ADDR_N_LO = 4'h4;
	localparam logic [3:0] ADDR_N_IF = 4'h5;
	localparam logic [3:0] ADDR_R_HI = 4'h6;
	localparam logic [3:0] ADDR_R_LO = 4'h7;
	localparam logic [3:0] ADDR_R_IF = 4'h8;

	// field positions in the power-control word
	localparam int RF_PWR_BIT = 0;
	localparam int IF_PWR_BIT = 1;
	// if output divide code within the main config word
	localparam int IF_OUTPUT_DIVIDE_LSB  = 10;

	localparam logic [17:0] DATA_RST = 18'h00000;
	localparam logic [17:0] PWR_RST  = 18'h00003;
	localparam logic [3:0]  TUNE_PERIODS = 4'hD;
	localparam int          PLL_COUNT    = 2;
	localparam int          PLL_IF       = 0;
	localparam int          PLL_RF       = 1;

	typedef enum logic [1:0] {
		TN_IDLE = 2'b01,
		TN_RUN  = 2'b10
	} ssc_tune_t;

	typedef struct packed {
		logic [17:0] hi_n;
		logic [17:0] lo_n;
		logic [17:0] if_n;
		logic [17:0] hi_r;
		logic [17:0] lo_r;
		logic [17:0] if_r;
	} ssc_div_t;

	typedef struct packed {
		logic pup_req;
		logic pdn_req;
	} ssc_pwr_ev_t;
endpackage : ssc_pkg

// >>> dv/ssc_host_model.sv
// host-side serial writer for the synth config port
// assumes one caller at a time; link timing is its own, async to clock
module ssc_host_model (
	output logic serial_clk,
	output logic serial_enable_n,
	output logic serial_data_in
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		serial_clk = 1'b0;
		serial_enable_n = 1'b1;
		serial_data_in = 1'b0;
	end

	task automatic put_bit(input logic b);
		serial_data_in = b;
		#200;
		serial_clk = 1'b1;
		#200;
		serial_clk = 1'b0;
	endtask : put_bit

	task automatic frame(input logic [21:0] word, input logic [3:0] lead,
		input bit use_lead);
		serial_enable_n = 1'b0;
		if (use_lead)
			for (int i = 3; i >= 0; i--)
				put_bit(lead[i]);
		for (int i = 21; i >= 0; i--)
			put_bit(word[i]);
		#200;
		serial_enable_n = 1'b1;
		// a released line must not keep showing the last bit
		serial_data_in = ~serial_data_in;
		#400;
	endtask : frame
endmodule : ssc_host_model

// >>> dv/tb_ssc_top.sv
// self-checking bench for the synth serial config port
// assumes ssc_pkg is compiled first; host model drives the serial pins
module tb_ssc_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic                 clock;
	logic                 rst_n;
	logic                 power_down_n_pin;
	logic                 pd_update_tick;
	logic                 serial_clk;
	logic                 serial_enable_n;
	logic                 serial_data_in;
	ssc_pkg::ssc_div_t    dividers;
	logic [17:0]          main_cfg;
	logic [17:0]          gain_cfg;
	logic [1:0]           if_output_divide;
	logic [3:0]           if_divide_ratio;
	logic                 low_band_synth_sel;
	logic                 if_pll_on;
	logic                 rf_pll_on;
	logic                 if_tuning;
	logic                 rf_tuning;
	logic                 lock_detect_n;
	logic                 word_commit;
	ssc_pkg::ssc_pwr_ev_t power_events;
	int n_mismatch = 0;
	int samples_checked = 0;
	int n_pup = 0;
	int n_pdn = 0;
	int n_commit = 0;
	int tcnt = 0;
	int tlast = 0;
	int cycles = 0;
	logic [2:0] tick_div = 3'h0;

	ssc_top i_dut (.clock(clock), .rst_n(rst_n), .serial_clk(serial_clk),
		.serial_enable_n(serial_enable_n), .serial_data_in(serial_data_in),
		.power_down_n_pin(power_down_n_pin), .pd_update_tick(pd_update_tick),
		.dividers(dividers), .main_cfg(main_cfg), .gain_cfg(gain_cfg),
		.if_output_divide(if_output_divide),
		.if_divide_ratio(if_divide_ratio),
		.low_band_synth_sel(low_band_synth_sel), .if_pll_on(if_pll_on),
		.rf_pll_on(rf_pll_on), .if_tuning(if_tuning), .rf_tuning(rf_tuning),
		.lock_detect_n(lock_detect_n), .word_commit(word_commit),
		.power_events(power_events));
	ssc_host_model i_host (.serial_clk(serial_clk),
		.serial_enable_n(serial_enable_n), .serial_data_in(serial_data_in));

	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// tick every 8 cycles; ticks seen while if_tuning is high are counted per run
	always @(posedge clock)
	begin
		tick_div <= tick_div + 3'h1;
		pd_update_tick <= #1 (tick_div == 3'h7);
		n_pup <= n_pup + int'(power_events.pup_req === 1'b1);
		n_pdn <= n_pdn + int'(power_events.pdn_req === 1'b1);
		n_commit <= n_commit + int'(word_commit === 1'b1);
		if (if_tuning === 1'b1)
			tcnt <= tcnt + int'(pd_update_tick === 1'b1);
		else if (tcnt != 0)
		begin
			tlast <= tcnt;
			tcnt <= 0;
		end
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_mismatch++;
			$display("timeout: bench did not finish");
			conclude();
		end
	end

	task automatic check(input string name, input logic [17:0] exp,
		input logic [17:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step

	// send a word; the one-cycle commit pulse is over before frame returns,
	// so the monitor above counts it
	task automatic wr(input logic [3:0] addr, input logic [17:0] data,
		input bit lead);
		int p;
		p = n_commit;
		i_host.frame({data, addr}, 4'hF, lead);
		check("word_commit", 18'h00001, 18'(n_commit - p));
	endtask : wr

	task automatic wait_idle();
		for (int i = 0; i < 400 && lock_detect_n !== 1'b0; i++)
			step(1);
		check("idle", 18'h00000, {17'h0, lock_detect_n});
	endtask : wait_idle

	task automatic t_reset();
		check("hi_n", 18'h00000, dividers.hi_n);
		check("ratio", 18'h00001, {14'h0, if_divide_ratio});
		check("band", 18'h00000, {17'h0, low_band_synth_sel});
		check("lock", 18'h00000, {17'h0, lock_detect_n});
	endtask : t_reset

	task automatic t_pin();
		int p;
		p = n_pup;
		power_down_n_pin = 1'b1;
		step(8);
		check("pin_pup", 18'h00001, 18'(n_pup - p));
		check("if_on", 18'h00001, {17'h0, if_pll_on});
		check("tune_pin", 18'h00001, {17'h0, lock_detect_n});
		wait_idle();
		p = n_pdn;
		power_down_n_pin = 1'b0;
		step(8);
		check("pin_pdn", 18'h00001, 18'(n_pdn - p));
		check("if_off", 18'h00000, {17'h0, if_pll_on});
		power_down_n_pin = 1'b1;
		step(8);
		wait_idle();
	endtask : t_pin

	task automatic t_band();
		wr(ssc_pkg::ADDR_N_LO, 18'h1234A, 1'b0);
		step(2);
		check("lo_n", 18'h1234A, dividers.lo_n);
		check("sel_lo", 18'h00001, {17'h0, low_band_synth_sel});
		check("rf_tune", 18'h00001, {17'h0, rf_tuning});
		wr(ssc_pkg::ADDR_R_HI, 18'h00C35, 1'b0);
		step(2);
		check("hi_r", 18'h00C35, dividers.hi_r);
		check("sel_hi", 18'h00000, {17'h0, low_band_synth_sel});
		wr(ssc_pkg::ADDR_R_LO, 18'h00A11, 1'b0);
		step(2);
		check("lo_r", 18'h00A11, dividers.lo_r);
		check("sel_lo2", 18'h00001, {17'h0, low_band_synth_sel});
		wr(ssc_pkg::ADDR_N_HI, 18'h1C3E5, 1'b0);
		step(2);
		check("hi_n", 18'h1C3E5, dividers.hi_n);
		check("sel_hi2", 18'h00000, {17'h0, low_band_synth_sel});
	endtask : t_band

	task automatic t_if_output_divide();
		for (int k = 0; k < 4; k++)
		begin
			wr(ssc_pkg::ADDR_MAIN, 18'(k << 10), 1'b0);
			step(2);
			check("if_output_divide", 18'(k), {16'h0, if_output_divide});
			check("ratio", 18'(1 << k), {14'h0, if_divide_ratio});
		end
	endtask : t_if_output_divide

	task automatic t_lead_unmapped();
		wr(ssc_pkg::ADDR_N_IF, 18'h2AAAA, 1'b1);
		step(1);
		check("lead", 18'h2AAAA, dividers.if_n);
		wr(ssc_pkg::ADDR_R_IF, 18'h00041, 1'b0);
		step(2);
		check("if_r", 18'h00041, dividers.if_r);
		check("if_tune", 18'h00001, {17'h0, if_tuning});
		wr(ssc_pkg::ADDR_GAIN, 18'h00015, 1'b0);
		step(2);
		check("gain", 18'h00015, gain_cfg);
		wr(4'h9, 18'h3FFFF, 1'b0);
		step(2);
		check("unmapped", 18'h00C00, main_cfg);
		check("unmap_g", 18'h00015, gain_cfg);
		check("unmap_d", 18'h00041, dividers.if_r);
	endtask : t_lead_unmapped

	task automatic t_soft_pwr();
		int p;
		int q;
		wait_idle();
		p = n_pdn;
		wr(ssc_pkg::ADDR_PWR, 18'h00000, 1'b0);
		step(3);
		check("sw_pdn", 18'h00001, 18'(n_pdn - p));
		check("rf_off", 18'h00000, {17'h0, rf_pll_on});
		p = n_pup;
		q = n_pdn;
		// only one power bit set: neither request, rf alone comes on
		wr(ssc_pkg::ADDR_PWR, 18'h00001, 1'b0);
		step(3);
		check("part_pup", 18'h00000, 18'(n_pup - p));
		check("part_pdn", 18'h00000, 18'(n_pdn - q));
		check("rf_only", 18'h00001, {17'h0, rf_pll_on});
		check("if_still_off", 18'h00000, {17'h0, if_pll_on});
		wr(ssc_pkg::ADDR_PWR, 18'h00003, 1'b0);
		step(3);
		check("sw_pup", 18'h00001, 18'(n_pup - p));
		check("rf_on", 18'h00001, {17'h0, rf_pll_on});
		check("sw_tune", 18'h00001, {17'h0, if_tuning});
		wait_idle();
	endtask : t_soft_pwr

	task automatic t_tune();
		tlast = 0;
		wr(ssc_pkg::ADDR_N_IF, 18'h00100, 1'b0);
		step(2);
		check("lock_n", 18'h00001, {17'h0, lock_detect_n});
		wait_idle();
		step(2);
		check("tune_len", 18'h0000D, 18'(tlast));
	endtask : t_tune

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	initial
	begin
		rst_n = 1'b0;
		power_down_n_pin = 1'b0;
		pd_update_tick = 1'b0;
		step(2);
		t_reset();
		rst_n = 1'b1;
		t_pin();
		t_band();
		t_if_output_divide();
		t_lead_unmapped();
		t_soft_pwr();
		t_tune();
		conclude();
	end
endmodule : tb_ssc_top
